// ==== verification/reset_cause_startup_control_tb.sv ====
/*
 Self-checking bench for the reset-cause and start-up block.
 Assumes one 125 MHz clock, a shortened timer count and the default filter count.
*/
`timescale 1ns/1ns
module reset_cause_startup_control_tb;
    import reset_cause_pkg::*;
    localparam int PWRT = 32;
    localparam int FILT = 4;
    logic clock, rst, ce, pinEn, low_voltage_program_enable, stkEn, pwrtN, holdLow, bor, prog, sleeping, global_irq_enable;
    logic [6:0] ev;
    logic [PC_W-1:0] pcCur, pcR;
    logic [7:0] addr, wdata, rdata, d;
    logic wrS, rdS;
    wire logic pinLevel, pinOut, pinOe, pullUp, coreReset, irq;
    pc_cmd_s pcCmd;
    int bad_count = 0, compares = 0, cyc = 0, n, pconM, stM;

    reset_cause_startup_control #(.PwrtCycles(PWRT), .FilterCycles(FILT)) dut (
        .clock(clock), .rst(rst), .ce(ce),
        .extResetPinEnable(pinEn), .lowVoltageProgramEnable(low_voltage_program_enable),
        .stackResetEnable(stkEn), .powerupTimerEnableN(pwrtN),
        .extResetPinIn(pinLevel), .extResetPinOut(pinOut), .extResetPinOe(pinOe),
        .extResetPullUp(pullUp), .brownoutLevel(bor), .programModeLevel(prog),
        .watchdogTimeout(ev[0]), .watchdogClearInstruction(ev[1]),
        .resetInstruction(ev[2]), .stackOverflow(ev[3]), .stackUnderflow(ev[4]),
        .sleepEnter(ev[6]), .sleeping(sleeping), .irqWake(ev[5]),
        .globalIrqEnable(global_irq_enable), .pcCurrent(pcCur), .coreReset(coreReset),
        .pcCmd(pcCmd), .regAddr(addr), .regWdata(wdata), .regWrite(wrS),
        .regRead(rdS), .regRdata(rdata), .irq(irq));

    reset_pin_partner partner (.clock(clock), .holdLow(holdLow), .devOut(pinOut),
        .devOe(pinOe), .pullUp(pullUp), .pinLevel(pinLevel));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        $display("mismatches %0d comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rdS <= 1'b1;
        @(posedge clock);
        rdS <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wrS <= 1'b1;
        @(posedge clock);
        wrS <= 1'b0;
        #1;
    endtask

    task automatic pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev[i] <= 1'b0;
        #1;
    endtask

    // Bounded wait for the core to leave reset; n holds the cycles taken.
    task automatic waitRun;
        n = 0;
        while (coreReset !== 1'b0 && n < 600) begin
            @(posedge clock);
            #1 n++;
        end
    endtask

    task automatic chkFlags;
        rd(REG_POWER_CONTROL);
        chk("powerFlags", pconM, d);
        rd(REG_CORE_STATUS);
        chk("coreStatus", stM, d & 8'h18);
    endtask

    task automatic resetEv(input int i, input int keep, input int set, input int stKeep);
        pulse(i);
        chk("coreReset", 1, coreReset);
        waitRun;
        chk("restartDelay", START_DELAY_CYC, n);
        chk("startPc", {1'b1, RESET_VECTOR}, {pcCmd.load, pcCmd.value});
        pconM = pconM & keep | set;
        stM = stM & stKeep;
        chkFlags;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, pinEn, low_voltage_program_enable, stkEn, pwrtN, holdLow, bor, prog} = 8'h80;
        {sleeping, global_irq_enable, ev, pcCur, addr, wdata, wrS, rdS} = '0;
        pinEn = 1'b1;
        ce = 1'b1;
        void'($urandom(8));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        waitRun;
        chk("pwrtHold", 1, n >= PWRT);
        pconM = 8'h1D;
        stM = 8'h18;
        chkFlags;
        rd(8'h20);
        chk("unmapped", 0, d);
        wr(REG_POWER_CONTROL, 8'hFF);
        pconM = 8'hDF;
        chkFlags;
        resetEv(2, 8'hFB, 0, 8'hFF);
        resetEv(0, 8'hEF, 0, 8'hEF);
        pulse(1);
        stM = 8'h18;
        chkFlags;
        pulse(3);
        chk("stackOff", 0, coreReset);
        @(posedge clock) stkEn <= 1'b1;
        // Clear both stack flags first so that their setting can be seen.
        pconM = pconM & 8'h3F;
        wr(REG_POWER_CONTROL, pconM[7:0]);
        resetEv(3, 8'hFF, 8'h80, 8'hFF);
        resetEv(4, 8'hFF, 8'h40, 8'hFF);
        repeat (4) begin
            @(posedge clock) holdLow <= 1'b1;
            repeat (1 + $urandom % 2) @(posedge clock);
            holdLow <= 1'b0;
            repeat (8) @(posedge clock);
            #1 chk("glitch", 0, coreReset);
        end
        @(posedge clock) holdLow <= 1'b1;
        repeat (20) @(posedge clock);
        #1 chk("pinHold", 1, coreReset);
        chk("pinDriven", 0, pinOe);
        chk("pinOut", 0, pinOut);
        @(posedge clock) holdLow <= 1'b0;
        waitRun;
        chk("pinStart", 1, n >= START_DELAY_CYC && n <= START_DELAY_CYC + FILT + 6);
        chk("pinPc", {1'b1, RESET_VECTOR}, {pcCmd.load, pcCmd.value});
        pconM = pconM & 8'hF7;
        chkFlags;
        for (int m = 3; m >= 0; m--) begin
            @(posedge clock);
            pinEn <= m[0];
            low_voltage_program_enable <= m[1];
            wr(REG_PIN_CONTROL, 8'h00);
            rd(REG_PIN_CONTROL);
            chk("pinResetOn", m != 0, d[2]);
            chk("pullUp", m != 0, pullUp);
        end
        @(posedge clock) holdLow <= 1'b1;
        repeat (20) @(posedge clock);
        #1 chk("pinOff", 0, coreReset);
        wr(REG_PIN_CONTROL, 8'h01);
        chk("swPullUp", 1, pullUp);
        @(posedge clock);
        holdLow <= 1'b0;
        // The filter must settle high before the pin reset is turned back on.
        repeat (8) @(posedge clock);
        pinEn <= 1'b1;
        repeat (12) @(posedge clock);
        pcR = PC_W'($urandom);
        @(posedge clock);
        pcCur <= pcR;
        sleeping <= 1'b1;
        global_irq_enable <= 1'b1;
        pulse(5);
        chk("wakeCmd", {1'b1, IRQ_VECTOR, 1'b1, pcR + 1'b1}, pcCmd);
        stM = 8'h10;
        chkFlags;
        pulse(0);
        chk("wdtWake", 0, coreReset);
        stM = 8'h00;
        chkFlags;
        @(posedge clock);
        sleeping <= 1'b0;
        pwrtN <= 1'b1;
        bor <= 1'b1;
        repeat (4) @(posedge clock);
        bor <= 1'b0;
        waitRun;
        chk("bypass", 1, n < PWRT);
        pconM = pconM & 8'h12 | 8'h0C;
        stM = 8'h18;
        chkFlags;
        @(posedge clock);
        pwrtN <= 1'b0;
        prog <= 1'b1;
        holdLow <= 1'b1;
        repeat (4) @(posedge clock);
        prog <= 1'b0;
        repeat (PWRT + 20) @(posedge clock);
        #1 chk("heldByPin", 1, coreReset);
        @(posedge clock) holdLow <= 1'b0;
        waitRun;
        chk("expiredStart", 1, n >= START_DELAY_CYC && n <= START_DELAY_CYC + FILT + 6);
        rd(REG_POWER_CONTROL);
        chk("progExit", 8'h15, d & 8'hF7);
        wr(REG_IRQ_MASK, 8'h00);
        wr(REG_IRQ_STATUS, 8'hFF);
        rd(REG_IRQ_STATUS);
        chk("irqClear", 0, d);
        pulse(2);
        waitRun;
        rd(REG_IRQ_STATUS);
        chk("irqStatus", 8'h08, d);
        chk("irqMasked", 0, irq);
        wr(REG_IRQ_MASK, 8'h08);
        chk("irqRaised", 1, irq);
        wr(REG_IRQ_STATUS, 8'h08);
        chk("irqDropped", 0, irq);
        @(posedge clock) ce <= 1'b0;
        pulse(2);
        @(posedge clock) ce <= 1'b1;
        @(posedge clock);
        #1 chk("ceFreeze", 0, coreReset);
        rd(REG_IRQ_STATUS);
        chk("ceIrq", 0, d);
        final_report;
    end
endmodule

// ==== verification/reset_pin_partner.sv ====
/*
 Reset pin partner: the board side of the external reset pin.
 Assumes the bench asks for a low pin and the pin rests on the pull-up.
*/
`timescale 1ns/1ns
module reset_pin_partner (
    // Clock.
    input wire logic clock,
    // Bench request and device pin controls.
    input wire logic holdLow,
    input wire logic devOut,
    input wire logic devOe,
    input wire logic pullUp,
    // Resolved pin level.
    output logic pinLevel
);
    logic drift;
    initial drift = 1'b0;
    // A floating pin toggles so that no stable guess can pass for a level.
    always @(posedge clock) drift <= ~drift;
    always_comb begin
        if (devOe) pinLevel = devOut;
        else if (holdLow) pinLevel = 1'b0;
        else if (pullUp) pinLevel = 1'b1;
        else pinLevel = drift;
    end
endmodule

// ==== verilog/reset_cause_pkg.sv ====
/*
 * Shared constants and carrier types for the reset-cause and start-up block.
 * Assumes a single core clock and register offsets decoded on a plain strobe port.
 */
package reset_cause_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int IRQ_W = 6;

    // Register offsets.
    localparam logic [7:0] REG_POWER_CONTROL = 8'h00;
    localparam logic [7:0] REG_CORE_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_PIN_CONTROL = 8'h10;

    // Power control register layout, bit 5 unimplemented.
    typedef struct packed {
        logic stackOverflowFlag;
        logic stackUnderflowFlag;
        logic unused;
        logic watchdogResetFlagN;
        logic pinResetFlagN;
        logic resetInstrFlagN;
        logic powerOnFlagN;
        logic brownoutFlagN;
    } power_control_s;

    localparam logic [7:0] POWER_CONTROL_REG_POR_VALUE = 8'h1D;
    localparam logic [7:0] POWER_CONTROL_REG_WRITE_MASK = 8'hDF;

    // Core status register fields.
    localparam int TIMEOUT_BIT = 4;
    localparam int POWERDOWN_BIT = 3;

    // Pin control register fields.
    localparam int PULLUP_BIT = 0;
    localparam int PIN_LEVEL_BIT = 1;
    localparam int PIN_RESET_ON_BIT = 2;

    // Interrupt cause bit positions.
    localparam int IRQ_POWER = 0;
    localparam int IRQ_PIN = 1;
    localparam int IRQ_WATCHDOG = 2;
    localparam int IRQ_INSTR = 3;
    localparam int IRQ_STACK = 4;
    localparam int IRQ_WAKE = 5;

    localparam logic [PC_W-1:0] RESET_VECTOR = 15'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 15'h0004;

    localparam int START_DELAY_CYC = 10;
    localparam int FILTER_CYC_DEFAULT = 4;
    localparam int PWRT_CYC_DEFAULT = 1024;

    typedef enum logic [1:0] {
        SEQ_POWER,
        SEQ_PIN_HOLD,
        SEQ_DELAY,
        SEQ_RUN
    } seq_e;

    typedef struct packed {
        logic load;
        logic [PC_W-1:0] value;
        logic push;
        logic [PC_W-1:0] pushAddr;
    } pc_cmd_s;

endpackage

// ==== verilog/reset_cause_startup_control.sv ====
/*
 * Reset-cause recording and start-up sequencing for a small core.
 * Assumes core events are one-cycle pulses on the core clock; the reset pin,
 * brown-out level and programming-mode level are asynchronous.
 */
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Pin reset on if enable or low-voltage programming.
// - Enabled low pin holds device in reset.
// - Short low glitches on pin are filtered.
// - Reset pin is never driven low.
// - Disabled pin is input, software pull-up.
// - Missed watchdog clear resets, marks timeout flags.
// - Reset instruction resets, clears its flag.
// - Stack fault resets when enabled, sets flag.
// - Programming exit behaves as power-on reset.
// - Power-up timer optional, active-low enable.
// - Start waits for timer and pin release.
// - Expired timer: run ten cycles after pin.
// - Brown-out updates cause flags as documented.
// - Power-on sets flags and vector zero.
// - Pin reset clears pin flag; in sleep it sets timeout, clears powerdown.
// - Watchdog wake continues at next address.
// - Interrupt wake continues, vectors if enabled.
module reset_cause_startup_control #(
    parameter int PwrtCycles = reset_cause_pkg::PWRT_CYC_DEFAULT,
    parameter int FilterCycles = reset_cause_pkg::FILTER_CYC_DEFAULT
) (
    // Clock, power-on reset and enable.
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Configuration settings.
    input wire logic extResetPinEnable,
    input wire logic lowVoltageProgramEnable,
    input wire logic stackResetEnable,
    input wire logic powerupTimerEnableN,
    // External reset pin.
    input wire logic extResetPinIn,
    output logic extResetPinOut,
    output logic extResetPinOe,
    output logic extResetPullUp,
    // Analog and programming levels.
    input wire logic brownoutLevel,
    input wire logic programModeLevel,
    // Core events.
    input wire logic watchdogTimeout,
    input wire logic watchdogClearInstruction,
    input wire logic resetInstruction,
    input wire logic stackOverflow,
    input wire logic stackUnderflow,
    input wire logic sleepEnter,
    input wire logic sleeping,
    input wire logic irqWake,
    input wire logic globalIrqEnable,
    input wire logic [reset_cause_pkg::PC_W-1:0] pcCurrent,
    // Core control.
    output logic coreReset,
    output reset_cause_pkg::pc_cmd_s pcCmd,
    // Register port.
    input wire logic [reset_cause_pkg::ADDR_W-1:0] regAddr,
    input wire logic [reset_cause_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [reset_cause_pkg::DATA_W-1:0] regRdata,
    // Interrupt.
    output logic irq
);
    import reset_cause_pkg::*;

    localparam int FILT_W = $clog2(FilterCycles + 1);
    localparam int PWRT_W = $clog2(PwrtCycles + 1);
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FilterCycles - 1);
    localparam logic [PWRT_W-1:0] PWRT_LAST = PWRT_W'(PwrtCycles - 1);
    localparam logic [3:0] DELAY_LAST = 4'(START_DELAY_CYC - 1);

    logic pinSync1_r, pinSync2_r, pinFilt_r;
    logic boSync1_r, boSync2_r, boPrev_r;
    logic pmSync1_r, pmSync2_r, pmPrev_r;
    logic [FILT_W-1:0] filtCnt_r;
    logic [PWRT_W-1:0] pwrtCnt_r;
    logic pwrtDone_r;
    logic [3:0] delayCnt_r;
    seq_e state_r, state_nxt;
    power_control_s power_control_reg_r;
    logic timeoutN_r, powerdownN_r;
    logic [IRQ_W-1:0] irqStatus_r, irqMask_r, irqEvents;
    logic pullUpSw_r;
    logic pinEnabled, pinLow, boRise, progExit, powerEvent;
    logic running, pinResetEv, wdtResetEv, instrResetEv, stackResetEv, restartEv;
    logic wdtWakeEv, irqWakeEv;
    logic pconWrite, irqStatusWrite;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and pin filter.

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinSync1_r <= 1'b1;
            pinSync2_r <= 1'b1;
            boSync1_r <= 1'b0;
            boSync2_r <= 1'b0;
            boPrev_r <= 1'b0;
            pmSync1_r <= 1'b0;
            pmSync2_r <= 1'b0;
            pmPrev_r <= 1'b0;
        end else if (ce) begin
            pinSync1_r <= extResetPinIn;
            pinSync2_r <= pinSync1_r;
            boSync1_r <= brownoutLevel;
            boSync2_r <= boSync1_r;
            boPrev_r <= boSync2_r;
            pmSync1_r <= programModeLevel;
            pmSync2_r <= pmSync1_r;
            pmPrev_r <= pmSync2_r;
        end
    end

    // A level must differ for FilterCycles cycles in a row before it is taken.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            filtCnt_r <= '0;
            pinFilt_r <= 1'b1;
        end else if (ce) begin
            if (pinSync2_r == pinFilt_r) begin
                filtCnt_r <= '0;
            end else if (filtCnt_r == FILT_LAST) begin
                filtCnt_r <= '0;
                pinFilt_r <= pinSync2_r;
            end else begin
                filtCnt_r <= filtCnt_r + 1'b1;
            end
        end
    end

    assign pinEnabled = extResetPinEnable | lowVoltageProgramEnable;
    assign pinLow = pinEnabled & ~pinFilt_r;
    // The pin is input only in every state.
    assign extResetPinOut = 1'b0;
    assign extResetPinOe = 1'b0;
    assign extResetPullUp = pinEnabled ? 1'b1 : pullUpSw_r;

    assign boRise = boSync2_r & ~boPrev_r;
    assign progExit = ~pmSync2_r & pmPrev_r;
    assign powerEvent = boRise | progExit;

    ////////////////////////////////////////////////////////////////////////////
    // Power-up timer, free of the pin.

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwrtCnt_r <= '0;
            pwrtDone_r <= 1'b0;
        end else if (ce) begin
            if (powerEvent || boSync2_r) begin
                pwrtCnt_r <= '0;
                pwrtDone_r <= 1'b0;
            end else if (powerupTimerEnableN) begin
                pwrtDone_r <= 1'b1;
            end else if (!pwrtDone_r) begin
                pwrtCnt_r <= pwrtCnt_r + 1'b1;
                pwrtDone_r <= (pwrtCnt_r == PWRT_LAST);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start-up sequencer.

    assign running = (state_r == SEQ_RUN);
    assign pinResetEv = running & pinLow;
    assign wdtResetEv = running & ~pinLow & watchdogTimeout & ~sleeping;
    assign instrResetEv = running & ~pinLow & resetInstruction;
    assign stackResetEv = running & ~pinLow & stackResetEnable & (stackOverflow | stackUnderflow);
    assign restartEv = wdtResetEv | instrResetEv | stackResetEv;
    assign wdtWakeEv = running & ~pinLow & watchdogTimeout & sleeping;
    assign irqWakeEv = running & ~pinLow & irqWake & sleeping & ~watchdogTimeout;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SEQ_POWER: begin
                if (pwrtDone_r && !boSync2_r) begin
                    state_nxt = pinLow ? SEQ_PIN_HOLD : SEQ_RUN;
                end
            end
            SEQ_PIN_HOLD: begin
                if (!pinLow) begin
                    state_nxt = SEQ_DELAY;
                end
            end
            SEQ_DELAY: begin
                if (pinLow) begin
                    state_nxt = SEQ_PIN_HOLD;
                end else if (delayCnt_r == DELAY_LAST) begin
                    state_nxt = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (pinLow) begin
                    state_nxt = SEQ_PIN_HOLD;
                end else if (restartEv) begin
                    state_nxt = SEQ_DELAY;
                end
            end
            default: state_nxt = SEQ_POWER;
        endcase
        if (powerEvent || boSync2_r) begin
            state_nxt = SEQ_POWER;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= SEQ_POWER;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            delayCnt_r <= '0;
        end else if (ce) begin
            delayCnt_r <= (state_r == SEQ_DELAY && !pinLow) ? delayCnt_r + 1'b1 : 4'h0;
        end
    end

    // Program counter commands: restart, next address, or interrupt vector.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pcCmd <= '0;
        end else if (ce) begin
            pcCmd <= '0;
            if (!running && state_nxt == SEQ_RUN) begin
                pcCmd.load <= 1'b1;
                pcCmd.value <= RESET_VECTOR;
            end else if (wdtWakeEv) begin
                pcCmd.load <= 1'b1;
                pcCmd.value <= pcCurrent + 1'b1;
            end else if (irqWakeEv) begin
                pcCmd.load <= 1'b1;
                pcCmd.value <= globalIrqEnable ? IRQ_VECTOR : pcCurrent + 1'b1;
                pcCmd.push <= globalIrqEnable;
                pcCmd.pushAddr <= pcCurrent + 1'b1;
            end
        end
    end

    assign coreReset = ~running;

    ////////////////////////////////////////////////////////////////////////////
    // Cause flags. Firmware writes land first so a same-cycle event wins.

    assign pconWrite = regWrite && regAddr == REG_POWER_CONTROL;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            power_control_reg_r <= POWER_CONTROL_REG_POR_VALUE;
        end else if (ce) begin
            if (pconWrite) begin
                power_control_reg_r <= power_control_s'(regWdata & POWER_CONTROL_REG_WRITE_MASK);
            end
            if (progExit) begin
                power_control_reg_r <= POWER_CONTROL_REG_POR_VALUE;
            end else if (boRise) begin
                power_control_reg_r.stackOverflowFlag <= 1'b0;
                power_control_reg_r.stackUnderflowFlag <= 1'b0;
                power_control_reg_r.pinResetFlagN <= 1'b1;
                power_control_reg_r.resetInstrFlagN <= 1'b1;
                power_control_reg_r.brownoutFlagN <= 1'b0;
            end else begin
                // Flags not named by the cause keep their value.
                if (pinResetEv) power_control_reg_r.pinResetFlagN <= 1'b0;
                if (wdtResetEv) power_control_reg_r.watchdogResetFlagN <= 1'b0;
                if (instrResetEv) power_control_reg_r.resetInstrFlagN <= 1'b0;
                if (stackResetEv && stackOverflow) power_control_reg_r.stackOverflowFlag <= 1'b1;
                if (stackResetEv && stackUnderflow) power_control_reg_r.stackUnderflowFlag <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timeoutN_r <= 1'b1;
            powerdownN_r <= 1'b1;
        end else if (ce) begin
            if (powerEvent) begin
                timeoutN_r <= 1'b1;
                powerdownN_r <= 1'b1;
            end else if (pinResetEv && sleeping) begin
                timeoutN_r <= 1'b1;
                powerdownN_r <= 1'b0;
            end else if (wdtWakeEv) begin
                timeoutN_r <= 1'b0;
                powerdownN_r <= 1'b0;
            end else if (wdtResetEv) begin
                timeoutN_r <= 1'b0;
            end else if (irqWakeEv) begin
                timeoutN_r <= 1'b1;
                powerdownN_r <= 1'b0;
            end else if (watchdogClearInstruction) begin
                timeoutN_r <= 1'b1;
                powerdownN_r <= 1'b1;
            end else if (sleepEnter) begin
                timeoutN_r <= 1'b1;
                powerdownN_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and register port.

    assign irqEvents = {wdtWakeEv | irqWakeEv, stackResetEv, instrResetEv, wdtResetEv,
        pinResetEv, powerEvent};
    assign irqStatusWrite = regWrite && regAddr == REG_IRQ_STATUS;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStatus_r <= '0;
            irqMask_r <= '0;
            pullUpSw_r <= 1'b0;
        end else if (ce) begin
            irqStatus_r <= (irqStatus_r & ~(irqStatusWrite ? regWdata[IRQ_W-1:0] : '0))
                | irqEvents;
            if (regWrite && regAddr == REG_IRQ_MASK) begin
                irqMask_r <= regWdata[IRQ_W-1:0];
            end
            if (regWrite && regAddr == REG_PIN_CONTROL) begin
                pullUpSw_r <= regWdata[PULLUP_BIT];
            end
        end
    end

    assign irq = |(irqStatus_r & irqMask_r);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdata <= '0;
        end else if (ce) begin
            regRdata <= '0;
            if (regRead) begin
                case (regAddr)
                    REG_POWER_CONTROL: regRdata <= power_control_reg_r;
                    REG_CORE_STATUS: begin
                        regRdata[TIMEOUT_BIT] <= timeoutN_r;
                        regRdata[POWERDOWN_BIT] <= powerdownN_r;
                    end
                    REG_IRQ_STATUS: regRdata <= DATA_W'(irqStatus_r);
                    REG_IRQ_MASK: regRdata <= DATA_W'(irqMask_r);
                    REG_PIN_CONTROL: begin
                        regRdata[PULLUP_BIT] <= pullUpSw_r;
                        regRdata[PIN_LEVEL_BIT] <= pinSync2_r;
                        regRdata[PIN_RESET_ON_BIT] <= pinEnabled;
                    end
                    default: regRdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !ce);

    property p_pin_enable;
        !extResetPinEnable && !lowVoltageProgramEnable |-> !pinLow;
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("pin reset active while disabled");

    property p_pin_holds;
        pinLow |=> !running;
    endproperty
    a_pin_holds: assert property (p_pin_holds) else $error("core ran with pin held low");

    sequence s_glitch;
        $fell(pinSync2_r) ##1 $rose(pinSync2_r);
    endsequence
    property p_glitch;
        pinFilt_r ##0 s_glitch |-> pinFilt_r;
    endproperty
    a_glitch: assert property (p_glitch) else $error("one-cycle glitch passed filter");

    property p_no_drive;
        !extResetPinOe && !extResetPinOut;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("reset pin driven");

    property p_pullup_sw;
        !pinEnabled |-> extResetPullUp == pullUpSw_r;
    endproperty
    a_pullup_sw: assert property (p_pullup_sw) else $error("pull-up not under software");

    property p_instr;
        instrResetEv |=> !power_control_reg_r.resetInstrFlagN && state_r == SEQ_DELAY;
    endproperty
    a_instr: assert property (p_instr) else $error("reset instruction not recorded");

    property p_stack;
        stackResetEv && stackOverflow |=> power_control_reg_r.stackOverflowFlag && !running;
    endproperty
    a_stack: assert property (p_stack) else $error("stack overflow reset missing");

    property p_prog_exit;
        progExit |=> power_control_reg_r == POWER_CONTROL_REG_POR_VALUE && state_r == SEQ_POWER;
    endproperty
    a_prog_exit: assert property (p_prog_exit) else $error("programming exit not a power-on");

    sequence s_release;
        state_r == SEQ_PIN_HOLD && !pinLow && ce;
    endsequence
    property p_ten_cycles;
        s_release |=> !running [*8] ##1 !running [*2] ##1 (running || pinLow || boSync2_r);
    endproperty
    a_ten_cycles: assert property (p_ten_cycles) else $error("start delay not ten cycles");

    property p_brownout;
        boRise && !progExit |=> !power_control_reg_r.brownoutFlagN && power_control_reg_r.pinResetFlagN && timeoutN_r;
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out flags wrong");

    property p_wdt_wake;
        wdtWakeEv |=> pcCmd.load && pcCmd.value == $past(pcCurrent) + 1'b1 && !timeoutN_r;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

    property p_irq_vector;
        irqWakeEv && globalIrqEnable |=> pcCmd.push && pcCmd.value == IRQ_VECTOR;
    endproperty
    a_irq_vector: assert property (p_irq_vector) else $error("interrupt wake no vector");

endmodule
